// file: hw/rmpc_pin_ctrl.sv
`timescale 1ns/1ps
// Contract
// - SPI mode: reset pin low holds the whole chip in reset.
// - During reset all settings default and serial communication is refused, like power-on.
// - During reset internal clocks stop; only the input structure keeps the master clock.
// - Analog biases stay on during reset so the part runs right after release.
// - Two-wire mode: reset pin is oversample bit 0, captured on entry and watchdog reset.
// - Modulator output pin is high impedance while its enable bit is low.
// - Enabled modulator pin carries the bitstream, updated once per analog clock period.
// - Enabled modulator output disables the conversion done output.
// - Two-wire mode forces the modulator pin to high impedance regardless of enable.
// - External reference select high disables the internal reference outside chip reset.
// - External reference select low enables internal reference and closes its pin switch.
// - Mode pin low selects SPI, high two-wire; latched after any reset kind; power-on latches SPI from the synchroniser's idle mode level.
// - Analog master clock is the master clock divided by 1, 2, 4 or 8 for prescale setting 0 to 3.
module rmpc_pin_ctrl
   import rmpc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic reset_oversample_select_bit0_n_i,
   input wire logic mode_pin_i,
   input wire logic watchdog_reset_i,
   input wire logic modulator_output_enable_i,
   input wire logic external_reference_select_i,
   input wire logic [RMPC_PRE_W-1:0] prescale_sel_i,
   input wire logic modulator_bit_i,
   input wire logic conversion_done_i,
   output logic chip_reset_o,
   output logic comm_enable_o,
   output logic clock_dist_en_o,
   output logic input_clock_en_o,
   output logic analog_bias_en_o,
   output logic twowire_mode_o,
   output logic oversample_select_bit0_o,
   output logic analog_master_clock_o,
   output logic modulator_bitstream_out_o,
   output logic modulator_bitstream_oe_o,
   output logic conversion_done_strobe_o,
   output logic conversion_done_oe_o,
   output logic int_vref_en_o,
   output logic vref_switch_close_o
);

   typedef struct packed {
      logic mode_pending;
      logic chip_rst;
      logic comm_en;
      logic clk_dist;
      logic bias_en;
      logic twowire;
      logic oversample_select_bit0;
      logic [RMPC_CNT_W-1:0] div_cnt;
      logic analog_master_clock_tick;
      logic mdat;
      logic mdat_oe;
      logic done;
      logic done_oe;
      logic vref_en;
   } rmpc_state_t;

   rmpc_state_t st;
   rmpc_state_t next_st;
   rmpc_sync_if sif();
   logic rst_pin;
   logic mode_pin;
   logic [RMPC_CNT_W-1:0] div_last;
   logic tick_now;

   assign sif.raw = {mode_pin_i, reset_oversample_select_bit0_n_i};
   assign rst_pin = sif.clean[RMPC_SYNC_RST];
   assign mode_pin = sif.clean[RMPC_SYNC_MODE];

   rmpc_sync u_sync (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .sif(sif)
   );

   // ----------------------------------------
   // Prescaler selection
   // ----------------------------------------
   always_comb begin
      case (prescale_sel_i)
         2'h0: div_last = RMPC_PRE_LAST_0;
         2'h1: div_last = RMPC_PRE_LAST_1;
         2'h2: div_last = RMPC_PRE_LAST_2;
         default: div_last = RMPC_PRE_LAST_3;
      endcase
   end

   assign tick_now = (st.div_cnt >= div_last);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.bias_en = 1'b1;
      // Mode is sampled only at reset events so a moving pin cannot flip the interface
      if (st.mode_pending || st.chip_rst || watchdog_reset_i) begin
         next_st.twowire = mode_pin;
      end
      next_st.mode_pending = 1'b0;
      // Reset pin is only a reset in SPI mode; the clean level is already clock aligned
      next_st.chip_rst = !next_st.twowire && !rst_pin;
      if (next_st.twowire && (!st.twowire || watchdog_reset_i)) begin
         next_st.oversample_select_bit0 = rst_pin;
      end
      next_st.comm_en = !next_st.chip_rst;
      next_st.clk_dist = !next_st.chip_rst;
      if (next_st.chip_rst) begin
         next_st.div_cnt = RMPC_CNT_ZERO;
         next_st.analog_master_clock_tick = 1'b0;
      end else if (tick_now) begin
         next_st.div_cnt = RMPC_CNT_ZERO;
         next_st.analog_master_clock_tick = 1'b1;
      end else begin
         next_st.div_cnt = st.div_cnt + RMPC_CNT_ONE;
         next_st.analog_master_clock_tick = 1'b0;
      end
      next_st.mdat_oe = modulator_output_enable_i && !next_st.twowire && !next_st.chip_rst;
      if (!next_st.mdat_oe) begin
         next_st.mdat = 1'b0;
      end else if (next_st.analog_master_clock_tick) begin
         next_st.mdat = modulator_bit_i;
      end
      next_st.done_oe = !next_st.mdat_oe && !next_st.twowire && !next_st.chip_rst;
      next_st.done = next_st.done_oe && conversion_done_i;
      // Settings fall back to default while the chip is held
      next_st.vref_en = next_st.chip_rst || !external_reference_select_i;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st <= '0;
         st.mode_pending <= 1'b1;
         st.chip_rst <= 1'b1;
         st.vref_en <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign chip_reset_o = st.chip_rst;
   assign comm_enable_o = st.comm_en;
   assign clock_dist_en_o = st.clk_dist;
   assign input_clock_en_o = st.bias_en;
   assign analog_bias_en_o = st.bias_en;
   assign twowire_mode_o = st.twowire;
   assign oversample_select_bit0_o = st.oversample_select_bit0;
   assign analog_master_clock_o = st.analog_master_clock_tick;
   assign modulator_bitstream_out_o = st.mdat;
   assign modulator_bitstream_oe_o = st.mdat_oe;
   assign conversion_done_strobe_o = st.done;
   assign conversion_done_oe_o = st.done_oe;
   assign int_vref_en_o = st.vref_en;
   assign vref_switch_close_o = st.vref_en;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   // Mode pin low as well, since a held chip reset may legally latch two-wire mode instead
   a_reset_hold: assert property (!twowire_mode_o && !rst_pin && !mode_pin |=> chip_reset_o)
      else $error("reset pin low in SPI mode did not hold chip reset");
   a_reset_comm: assert property (chip_reset_o |-> !comm_enable_o && !modulator_bitstream_oe_o)
      else $error("communication allowed during reset");
   a_clock_stop: assert property (chip_reset_o |-> !clock_dist_en_o && !analog_master_clock_o)
      else $error("clocks distributed during reset");
   a_bias_on: assert property ($past(!srst_i) |-> analog_bias_en_o && input_clock_en_o)
      else $error("analog bias dropped");
   a_osr_entry: assert property ($rose(twowire_mode_o) |-> oversample_select_bit0_o == $past(rst_pin))
      else $error("oversample bit not captured on two-wire entry");
   a_mdat_gate: assert property (modulator_bitstream_oe_o |-> $past(modulator_output_enable_i))
      else $error("modulator pin driven while disabled");
   a_mdat_rate: assert property ($changed(modulator_bitstream_out_o) && modulator_bitstream_oe_o
      |-> analog_master_clock_o)
      else $error("bitstream changed off the analog clock tick");
   a_done_off: assert property (modulator_bitstream_oe_o |-> !conversion_done_oe_o && !conversion_done_strobe_o)
      else $error("done output active with modulator output");
   a_twowire_hiz: assert property (twowire_mode_o |-> !modulator_bitstream_oe_o)
      else $error("modulator pin driven in two-wire mode");
   a_vref_sel: assert property ($past(external_reference_select_i) && !chip_reset_o |-> !int_vref_en_o)
      else $error("internal reference left on");
   a_vref_int: assert property ($past(!external_reference_select_i) |-> int_vref_en_o && vref_switch_close_o)
      else $error("internal reference not connected");
   a_tick_gap: assert property (analog_master_clock_o && prescale_sel_i == 2'h2
      ##1 (prescale_sel_i == 2'h2)[*3]
      |-> !analog_master_clock_o && $past(!analog_master_clock_o) && $past(!analog_master_clock_o, 2))
      else $error("analog clock tick spacing too short");
   a_tick_period: assert property (analog_master_clock_o && prescale_sel_i == 2'h2
      ##1 (prescale_sel_i == 2'h2 && !chip_reset_o)[*3] |=> analog_master_clock_o || chip_reset_o)
      else $error("analog clock tick missing after four cycles");

endmodule

// file: hw/rmpc_sync.sv
`timescale 1ns/1ps
module rmpc_sync
   import rmpc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   rmpc_sync_if.sync_side sif
);

   typedef struct packed {
      logic [RMPC_SYNC_W-1:0] s1;
      logic [RMPC_SYNC_W-1:0] s2;
      logic [RMPC_SYNC_W-1:0] s3;
      logic [RMPC_SYNC_W-1:0] clean;
   } rmpc_sync_st_t;

   rmpc_sync_st_t st;
   rmpc_sync_st_t next_st;

   // ----------------------------------------
   // Three stages, accept once two and three agree
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.s1 = sif.raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Per bit so a glitch on one pin does not stall the other
      for (int i = 0; i < RMPC_SYNC_W; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.clean[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st <= '{s1: RMPC_SYNC_INIT, s2: RMPC_SYNC_INIT, s3: RMPC_SYNC_INIT, clean: RMPC_SYNC_INIT};
      end else begin
         st <= next_st;
      end
   end

   assign sif.clean = st.clean;

endmodule

// file: pkg/rmpc_pkg.sv
package rmpc_pkg;

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   localparam int RMPC_PRE_W = 2;
   localparam int RMPC_CNT_W = 3;
   // Divide-by minus one for each prescaler setting
   localparam logic [2:0] RMPC_PRE_LAST_0 = 3'h0;
   localparam logic [2:0] RMPC_PRE_LAST_1 = 3'h1;
   localparam logic [2:0] RMPC_PRE_LAST_2 = 3'h3;
   localparam logic [2:0] RMPC_PRE_LAST_3 = 3'h7;
   localparam logic [2:0] RMPC_CNT_ZERO = 3'h0;
   localparam logic [2:0] RMPC_CNT_ONE = 3'h1;

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   localparam int RMPC_SYNC_W = 2;
   localparam int RMPC_SYNC_RST = 0;
   localparam int RMPC_SYNC_MODE = 1;
   // Reset pin idles high, mode pin idles low
   localparam logic [1:0] RMPC_SYNC_INIT = 2'h1;

endpackage

// file: pkg/rmpc_sync_if.sv
`timescale 1ns/1ps
interface rmpc_sync_if;
   import rmpc_pkg::*;
   logic [RMPC_SYNC_W-1:0] raw;
   logic [RMPC_SYNC_W-1:0] clean;
   modport sync_side (input raw, output clean);
   modport user_side (output raw, input clean);
endinterface

// file: verif/reset_and_modulator_pin_control_test.sv
`timescale 1ns/1ps
module reset_and_modulator_pin_control_test;
   import rmpc_pkg::*;
   // ----
   // Stimulus and checks
   // ----
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic rst_n = 1'b1, mode = 1'b0, wdog = 1'b0, en = 1'b0, ext = 1'b0, mbit = 1'b0, done = 1'b0, clr = 1'b1;
   logic [RMPC_PRE_W-1:0] pre = '0;
   logic crst, comm, clkd, inclk, bias, tw, oversample_select_bit0, tick, mout, moe, dstb, doe, vref, vsw, mwire, dwire;
   logic last_bit, last_done, last_moe, last_doe, v;
   logic [7:0] ticks;
   int errors = 0;
   int cmp_count = 0;
   int seed = 32'h6239;
   rmpc_pin_ctrl rmpc_pin_ctrl_i (.mclk_i(mclk_i), .srst_i(srst_i), .reset_oversample_select_bit0_n_i(rst_n), .mode_pin_i(mode),
      .watchdog_reset_i(wdog), .modulator_output_enable_i(en), .external_reference_select_i(ext),
      .prescale_sel_i(pre), .modulator_bit_i(mbit), .conversion_done_i(done), .chip_reset_o(crst),
      .comm_enable_o(comm), .clock_dist_en_o(clkd), .input_clock_en_o(inclk), .analog_bias_en_o(bias),
      .twowire_mode_o(tw), .oversample_select_bit0_o(oversample_select_bit0), .analog_master_clock_o(tick),
      .modulator_bitstream_out_o(mout), .modulator_bitstream_oe_o(moe), .conversion_done_strobe_o(dstb),
      .conversion_done_oe_o(doe), .int_vref_en_o(vref), .vref_switch_close_o(vsw));
   rmpc_host_model rmpc_host_model_i (.mclk_i(mclk_i), .clr_i(clr), .tick_i(tick), .mdat_i(mout),
      .mdat_oe_i(moe), .done_i(dstb), .done_oe_i(doe), .mdat_wire_o(mwire), .done_wire_o(dwire),
      .tick_count_o(ticks));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk_i);
   endtask
   task automatic end_of_test();
      $display("Counts: %0d errors in %0d compares", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      forever #25 mclk_i = ~mclk_i;
   end
   // Old values are what the design sampled at this edge
   always @(posedge mclk_i) begin
      last_bit <= mbit;
      last_done <= done;
      last_moe <= moe;
      last_doe <= doe;
      mbit <= 1'($random(seed));
      done <= 1'($random(seed));
   end
   // Skip the edge where an enable turns, its gating is allowed to lag
   always @(negedge mclk_i) begin
      if (tick === 1'b1 && moe === 1'b1 && last_moe === 1'b1) check("mdat", mwire, last_bit);
      if (doe === 1'b1 && last_doe === 1'b1) check("done", dwire, last_done);
   end
   initial begin
      cyc(5);
      #1;
      check("rst", crst, 1'b1);
      check("comm", comm, 1'b0);
      check("vref", vref, 1'b1);
      cyc(1);
      srst_i <= 1'b0;
      cyc(8);
      #1;
      check("rst", crst, 1'b0);
      check("mode", tw, 1'b0);
      for (int i = 0; i < 8; i++) begin
         cyc(1);
         en <= 1'($random(seed));
         ext <= 1'($random(seed));
         pre <= RMPC_PRE_W'(i);
         cyc(12);
         #1;
         check("vref", vref, !ext);
         check("vsw", vsw, !ext);
         check("moe", moe, en);
         check("doe", doe, !en);
         cyc(1);
         clr <= 1'b0;
         cyc(16);
         clr <= 1'b1;
         #1;
         check("ticks", ticks, 8'(16 >> (i % 4)));
      end
      cyc(1);
      en <= 1'b1;
      rst_n <= 1'b0;
      cyc(8);
      #1;
      check("rst", crst, 1'b1);
      check("comm", comm, 1'b0);
      check("moe", moe, 1'b0);
      check("vref", vref, 1'b1);
      check("clkd", clkd, 1'b0);
      check("inclk", inclk, 1'b1);
      check("bias", bias, 1'b1);
      cyc(1);
      rst_n <= 1'b1;
      cyc(8);
      #1;
      check("rst", crst, 1'b0);
      check("comm", comm, 1'b1);
      check("clkd", clkd, 1'b1);
      check("moe", moe, 1'b1);
      cyc(1);
      mode <= 1'b1;
      rst_n <= 1'b0;
      cyc(12);
      #1;
      check("mode", tw, 1'b1);
      check("oversample_select_bit0", oversample_select_bit0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         v = 1'($random(seed));
         cyc(1);
         rst_n <= v;
         cyc(6);
         wdog <= 1'b1;
         cyc(1);
         wdog <= 1'b0;
         cyc(3);
         #1;
         check("oversample_select_bit0", oversample_select_bit0, v);
         check("rst", crst, 1'b0);
         check("moe", moe, 1'b0);
      end
      cyc(1);
      mode <= 1'b0;
      rst_n <= 1'b1;
      cyc(6);
      wdog <= 1'b1;
      cyc(1);
      wdog <= 1'b0;
      cyc(3);
      #1;
      check("mode", tw, 1'b0);
      check("moe", moe, 1'b1);
      end_of_test();
   end
endmodule

// file: verif/rmpc_host_model.sv
`timescale 1ns/1ps
// ----
// Host side of the modulator and done pins
// ----
module rmpc_host_model (
   input wire logic mclk_i,
   input wire logic clr_i,
   input wire logic tick_i,
   input wire logic mdat_i,
   input wire logic mdat_oe_i,
   input wire logic done_i,
   input wire logic done_oe_i,
   output logic mdat_wire_o,
   output logic done_wire_o,
   output logic [7:0] tick_count_o
);
   logic last = 1'b0;
   // Released line has no pull, so it shows the inverse of its last level
   assign mdat_wire_o = mdat_oe_i ? mdat_i : ~last;
   // Pull-up holds the released done line high
   assign done_wire_o = done_oe_i ? done_i : 1'b1;
   always @(posedge mclk_i) begin
      if (mdat_oe_i) begin
         last <= mdat_i;
      end
      tick_count_o <= clr_i ? 8'h00 : tick_count_o + 8'(tick_i);
   end
endmodule
